// >>> hdl/reset_and_phy_powerdown_ctrl.sv
// Overview of operation
// - while phy control bit 11 is set, phy stays powered down except management.
// - clearing phy control bit 11 powers phy up and runs an automatic phy reset.
// - phy mode bit 13 set enables energy-detect power-down; cleared disables it.
// - energy-detect with no line energy powers phy down except management and detector.
// - energy low means no transmit; received energy raises energy_present and powers up.
// - energy power-up restores prior state then sets energy_on_flag, interrupt bit 1.
// - energy_on_flag with its enable set raises the host interrupt.
// - first one or two packets after energy wake may be dropped.
// - five reset sources: power-on, pin, soft, pmc phy reset, phy control reset.
// - soft reset leaves the not_affected_by_soft_reset register unchanged.
// - after power-on, pin or soft reset, eeprom_busy bit 31 stays set during probe.
// - power-on holds internal reset about 22 ms.
// - ready reads 0 until power-on reset completes, then is set.
// - hw_reset_pin_n low resets the device; ready 0 until that reset ends.
// - ready is set within 2 ms of a wake test register write.
// - hardware_config bit 0 starts soft reset and self-clears after about 2 us.
// - power_mgmt_control bit 10 resets phy and self-clears after about 100 us.
// - phy control bit 15 resets phy and self-clears when the reset is done.
// - power-saving states clear ready; any wake test write returns to normal.
`timescale 1ns/1ps
module reset_and_phy_powerdown_ctrl #(
  parameter int POR_CYCLES = rst_pwr_pkg::POR_CYC,
  parameter int WAKE_CYCLES = rst_pwr_pkg::WAKE_CYC,
  parameter int PHY_RST_CYCLES = rst_pwr_pkg::PHY_RST_CYC
) (
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  // device pins
  input wire logic HW_RESET_PIN_N_I,
  input wire logic LINE_ENERGY_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic [31:0] PRDATA_O,
  // status toward the rest of the chip
  output logic PHY_POWERED_O,
  output logic PHY_TX_ALLOW_O,
  output logic PHY_IRQ_O,
  output logic DEV_RESET_O
);
  localparam int CW = 32;
  rst_pwr_pkg::apb_req_s req;
  logic pin_s1_ff, pin_s2_ff, eng_s1_ff, eng_s2_ff;
  logic [CW-1:0] dev_cnt_ff, phy_cnt_ff, ee_cnt_ff, link_cnt_ff;
  logic dev_busy_ff, ready_ff, soft_reset_bit_ff, phy_rst_ff, phy_crst_ff, ee_busy_ff;
  logic pdn_ff, edpd_ff, eon_flag_ff, eon_en_ff, link_ff, phy_up_ff, eon_prev_ff;
  logic [31:0] not_affected_by_soft_reset_ff;
  logic [1:0] pm_mode_ff;
  logic wr, rd, dev_go, phy_go, eon_rise, pdn_now, energy_present;
  logic [31:0] nxt_rdata;
  logic nxt_err;

  assign req = '{sel: PSEL_I, en: PENABLE_I, wr: PWRITE_I, addr: PADDR_I, wdata: PWDATA_I};
  assign wr = req.sel && req.en && req.wr && PREADY_O == 1'b0;
  assign rd = req.sel && req.en && !req.wr && PREADY_O == 1'b0;

  // pin and line energy come from outside the clock domain
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      pin_s1_ff <= 1'b1;
      pin_s2_ff <= 1'b1;
      eng_s1_ff <= 1'b0;
      eng_s2_ff <= 1'b0;
    end else begin
      pin_s1_ff <= HW_RESET_PIN_N_I;
      pin_s2_ff <= pin_s1_ff;
      eng_s1_ff <= LINE_ENERGY_I;
      eng_s2_ff <= eng_s1_ff;
    end
  end

  assign energy_present = eng_s2_ff;
  // soft reset, pin reset and power-on each start the device counter
  assign dev_go = !pin_s2_ff || (wr && req.addr == rst_pwr_pkg::HWC_ADDR
                  && req.wdata[rst_pwr_pkg::HWC_SOFT_RESET_BIT_BIT]);

  // device reset timer; power-on is modelled by the system reset
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      dev_busy_ff <= 1'b1;
      soft_reset_bit_ff <= 1'b0;
      dev_cnt_ff <= CW'(POR_CYCLES);
    end else if (dev_go) begin
      dev_busy_ff <= 1'b1;
      soft_reset_bit_ff <= pin_s2_ff;
      dev_cnt_ff <= pin_s2_ff ? CW'(rst_pwr_pkg::SOFT_RESET_BIT_CYC) : CW'(1);
    end else if (dev_cnt_ff > CW'(1)) begin
      dev_cnt_ff <= dev_cnt_ff - CW'(1);
    end else begin
      dev_busy_ff <= 1'b0;
      soft_reset_bit_ff <= 1'b0;
      dev_cnt_ff <= '0;
    end
  end

  // eeprom probe follows every device-level reset
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I || dev_busy_ff) begin
      ee_busy_ff <= 1'b1;
      ee_cnt_ff <= CW'(rst_pwr_pkg::EE_PROBE_CYC);
    end else if (ee_cnt_ff != '0) begin
      ee_cnt_ff <= ee_cnt_ff - CW'(1);
    end else begin
      ee_busy_ff <= 1'b0;
    end
  end

  // power states; the wake delay is counted by the ready timer
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I || dev_busy_ff) begin
      pm_mode_ff <= rst_pwr_pkg::PM_D0;
    end else if (wr && req.addr == rst_pwr_pkg::WAKE_ADDR
                 && pm_mode_ff != rst_pwr_pkg::PM_D0) begin
      pm_mode_ff <= rst_pwr_pkg::PM_D0;
    end else if (wr && req.addr == rst_pwr_pkg::PMC_ADDR && ready_ff) begin
      pm_mode_ff <= req.wdata[rst_pwr_pkg::PMC_MODE_LSB +: 2];
    end
  end

  // ready: low in reset, low while asleep, high a fixed time after wake
  logic [CW-1:0] wake_cnt_ff;
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I || dev_busy_ff || dev_go) begin
      ready_ff <= 1'b0;
      wake_cnt_ff <= '0;
    end else if (pm_mode_ff != rst_pwr_pkg::PM_D0) begin
      ready_ff <= 1'b0;
      wake_cnt_ff <= CW'(WAKE_CYCLES);
    end else if (wake_cnt_ff > CW'(1)) begin
      wake_cnt_ff <= wake_cnt_ff - CW'(1);
    end else begin
      ready_ff <= 1'b1;
      wake_cnt_ff <= '0;
    end
  end

  assign phy_go = wr && ((req.addr == rst_pwr_pkg::PMC_ADDR
                  && req.wdata[rst_pwr_pkg::PMC_PHY_RST_BIT])
                  || (req.addr == rst_pwr_pkg::PHYC_ADDR
                  && req.wdata[rst_pwr_pkg::PHYC_RST_BIT]));
  // leaving general power-down triggers an automatic phy reset
  assign pdn_now = wr && req.addr == rst_pwr_pkg::PHYC_ADDR && pdn_ff
                   && !req.wdata[rst_pwr_pkg::PHYC_PDN_BIT];

  // phy reset timer, shared by all phy reset sources
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I || dev_busy_ff || phy_go || pdn_now) begin
      phy_cnt_ff <= CW'(PHY_RST_CYCLES);
      phy_rst_ff <= phy_go && req.addr == rst_pwr_pkg::PMC_ADDR;
      phy_crst_ff <= (phy_go && req.addr == rst_pwr_pkg::PHYC_ADDR) || pdn_now;
    end else if (phy_cnt_ff > CW'(1)) begin
      phy_cnt_ff <= phy_cnt_ff - CW'(1);
    end else begin
      phy_cnt_ff <= '0;
      phy_rst_ff <= 1'b0;
      phy_crst_ff <= 1'b0;
    end
  end

  // phy control bits; pmc and control-bit phy resets restore defaults, the power-down exit reset does not
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I || dev_busy_ff || phy_go) begin
      pdn_ff <= 1'b0;
      edpd_ff <= 1'b0;
      eon_en_ff <= 1'b0;
    end else if (wr && req.addr == rst_pwr_pkg::PHYC_ADDR) begin
      pdn_ff <= req.wdata[rst_pwr_pkg::PHYC_PDN_BIT];
    end else if (wr && req.addr == rst_pwr_pkg::PHYM_ADDR) begin
      edpd_ff <= req.wdata[rst_pwr_pkg::PHYM_EDPD_BIT];
    end else if (wr && req.addr == rst_pwr_pkg::PHYE_ADDR) begin
      eon_en_ff <= req.wdata[rst_pwr_pkg::PHYI_EON_BIT];
    end
  end

  // phy power: general power-down, or energy-detect without energy
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      phy_up_ff <= 1'b1;
      eon_prev_ff <= 1'b0;
    end else begin
      phy_up_ff <= !pdn_ff && !(edpd_ff && !energy_present);
      eon_prev_ff <= energy_present;
    end
  end

  // power-up by energy keeps configuration; packets during wake may be lost
  assign eon_rise = edpd_ff && energy_present && !eon_prev_ff && !pdn_ff;

  // energy_on_flag: clear on read, but a new event wins over the clear
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I || dev_busy_ff || phy_go) begin
      eon_flag_ff <= 1'b0;
    end else if (eon_rise) begin
      eon_flag_ff <= 1'b1;
    end else if (rd && req.addr == rst_pwr_pkg::PHYI_ADDR) begin
      eon_flag_ff <= 1'b0;
    end
  end

  // link comes up some time after the phy is out of reset and powered
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I || phy_cnt_ff != '0 || !phy_up_ff || !energy_present) begin
      link_ff <= 1'b0;
      link_cnt_ff <= CW'(rst_pwr_pkg::LINK_CYC);
    end else if (link_cnt_ff != '0) begin
      link_cnt_ff <= link_cnt_ff - CW'(1);
    end else begin
      link_ff <= 1'b1;
    end
  end

  // scratch register, untouched by soft reset
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I || (dev_busy_ff && !soft_reset_bit_ff && dev_cnt_ff == CW'(1) && !pin_s2_ff)) begin
      not_affected_by_soft_reset_ff <= rst_pwr_pkg::NOT_AFFECTED_BY_SOFT_RESET_RST;
    end else if (!pin_s2_ff) begin
      not_affected_by_soft_reset_ff <= rst_pwr_pkg::NOT_AFFECTED_BY_SOFT_RESET_RST;
    end else if (wr && req.addr == rst_pwr_pkg::NOT_AFFECTED_BY_SOFT_RESET_ADDR && ready_ff) begin
      not_affected_by_soft_reset_ff <= req.wdata;
    end
  end

  // read mux; every register reads at any time, software must check ready itself
  always_comb begin
    nxt_rdata = rst_pwr_pkg::BAD_ADDR_DATA;
    nxt_err = 1'b0;
    case (req.addr)
      rst_pwr_pkg::PMC_ADDR: begin
        nxt_rdata[rst_pwr_pkg::PMC_READY_BIT] = ready_ff;
        nxt_rdata[rst_pwr_pkg::PMC_PHY_RST_BIT] = phy_rst_ff;
        nxt_rdata[rst_pwr_pkg::PMC_MODE_LSB +: 2] = pm_mode_ff;
      end
      rst_pwr_pkg::HWC_ADDR: nxt_rdata[rst_pwr_pkg::HWC_SOFT_RESET_BIT_BIT] = soft_reset_bit_ff;
      rst_pwr_pkg::EEC_ADDR: nxt_rdata[rst_pwr_pkg::EEC_BUSY_BIT] = ee_busy_ff;
      rst_pwr_pkg::WAKE_ADDR: nxt_rdata = '0;
      rst_pwr_pkg::PHYC_ADDR: begin
        nxt_rdata[rst_pwr_pkg::PHYC_RST_BIT] = phy_crst_ff;
        nxt_rdata[rst_pwr_pkg::PHYC_PDN_BIT] = pdn_ff;
      end
      rst_pwr_pkg::PHYS_ADDR: nxt_rdata[rst_pwr_pkg::PHYS_LINK_BIT] = link_ff;
      rst_pwr_pkg::PHYM_ADDR: begin
        nxt_rdata[rst_pwr_pkg::PHYM_EDPD_BIT] = edpd_ff;
        nxt_rdata[rst_pwr_pkg::PHYM_EON_BIT] = energy_present;
      end
      rst_pwr_pkg::PHYI_ADDR: nxt_rdata[rst_pwr_pkg::PHYI_EON_BIT] = eon_flag_ff;
      rst_pwr_pkg::PHYE_ADDR: nxt_rdata[rst_pwr_pkg::PHYI_EON_BIT] = eon_en_ff;
      rst_pwr_pkg::NOT_AFFECTED_BY_SOFT_RESET_ADDR: nxt_rdata = not_affected_by_soft_reset_ff;
      default: nxt_err = 1'b1;
    endcase
  end

  // one wait state: pready rises the cycle after the access phase starts
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= '0;
    end else begin
      PREADY_O <= req.sel && req.en && !PREADY_O;
      PSLVERR_O <= req.sel && req.en && !PREADY_O && nxt_err;
      PRDATA_O <= (rd && !nxt_err) ? nxt_rdata : '0;
    end
  end

  // outputs toward the chip
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      PHY_POWERED_O <= 1'b0;
      PHY_TX_ALLOW_O <= 1'b0;
      PHY_IRQ_O <= 1'b0;
      DEV_RESET_O <= 1'b1;
    end else begin
      PHY_POWERED_O <= phy_up_ff;
      PHY_TX_ALLOW_O <= phy_up_ff && energy_present && phy_cnt_ff == '0;
      PHY_IRQ_O <= eon_flag_ff && eon_en_ff;
      DEV_RESET_O <= dev_busy_ff;
    end
  end

  // checks
  ready_after_reset_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    dev_busy_ff |-> !ready_ff) else $error("ready set during reset");
  soft_reset_clear_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    $rose(soft_reset_bit_ff) |-> ##[1:45] !soft_reset_bit_ff) else $error("soft reset bit stuck");
  pdn_powers_off_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    pdn_ff |=> !phy_up_ff) else $error("phy up in power-down");
  pdn_exit_reset_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    pdn_now |=> phy_crst_ff) else $error("no reset on power-down exit");
  edpd_no_energy_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    edpd_ff && !energy_present |=> !phy_up_ff) else $error("phy up without energy");
  energy_flag_set_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    eon_rise && !phy_go && !dev_busy_ff |=> eon_flag_ff) else $error("flag missed");
  irq_follows_flag_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    eon_flag_ff && eon_en_ff |=> PHY_IRQ_O) else $error("interrupt missed");
  eeprom_busy_reset_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    dev_busy_ff |=> ee_busy_ff) else $error("eeprom busy low in reset");
  sleep_clears_ready_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    pm_mode_ff != rst_pwr_pkg::PM_D0 |=> !ready_ff) else $error("ready while asleep");
  pdn_no_power_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    pdn_ff |-> ##2 !PHY_POWERED_O) else $error("powered output in power-down");
  pdn_no_tx_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    pdn_ff |-> ##2 !PHY_TX_ALLOW_O) else $error("transmit allowed in power-down");
  pdn_exit_clear_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    pdn_now |=> !pdn_ff) else $error("power-down not left");
  edpd_enable_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    wr && req.addr == rst_pwr_pkg::PHYM_ADDR && req.wdata[rst_pwr_pkg::PHYM_EDPD_BIT]
    && !dev_busy_ff |=> edpd_ff) else $error("energy-detect not enabled");
  edpd_disable_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    wr && req.addr == rst_pwr_pkg::PHYM_ADDR && !req.wdata[rst_pwr_pkg::PHYM_EDPD_BIT]
    |=> !edpd_ff) else $error("energy-detect not disabled");
  edpd_dark_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    edpd_ff && !energy_present |-> ##2 !PHY_POWERED_O) else $error("powered without energy");
  no_energy_no_tx_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    !energy_present |=> !PHY_TX_ALLOW_O) else $error("transmit without energy");
  energy_powers_up_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    edpd_ff && energy_present && !pdn_ff |=> phy_up_ff) else $error("no power-up on energy");
  flag_needs_event_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    $rose(eon_flag_ff) |-> $past(eon_rise)) else $error("flag set without energy event");
  irq_needs_flag_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    !(eon_flag_ff && eon_en_ff) |=> !PHY_IRQ_O) else $error("interrupt without flag");
  pin_holds_reset_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    !pin_s2_ff |=> dev_busy_ff) else $error("pin reset not applied");
  probe_after_reset_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    $fell(dev_busy_ff) |-> ee_busy_ff) else $error("eeprom probe not running");
  busy_hides_ready_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    DEV_RESET_O |-> !ready_ff) else $error("ready while device reset shown");
  wake_timer_runs_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    wake_cnt_ff != '0 && pm_mode_ff == rst_pwr_pkg::PM_D0 && !dev_busy_ff && !dev_go
    |=> wake_cnt_ff == $past(wake_cnt_ff) - CW'(1)) else $error("wake timer stalled");
  wake_write_d0_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    wr && req.addr == rst_pwr_pkg::WAKE_ADDR |=> pm_mode_ff == rst_pwr_pkg::PM_D0)
    else $error("still asleep after wake write");
  soft_reset_bit_keeps_scratch_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    soft_reset_bit_ff && pin_s2_ff |=> $stable(not_affected_by_soft_reset_ff)) else $error("scratch lost in soft reset");
  por_timer_holds_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    dev_busy_ff && dev_cnt_ff > CW'(1) && !dev_go |=> dev_busy_ff)
    else $error("reset ended early");
  phy_rst_done_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    phy_cnt_ff == CW'(1) && !phy_go && !pdn_now && !dev_busy_ff
    |=> !phy_rst_ff && !phy_crst_ff) else $error("phy reset bit stuck");
  link_down_in_reset_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    phy_cnt_ff != '0 |=> !link_ff) else $error("link up during phy reset");
endmodule // reset_and_phy_powerdown_ctrl

// >>> include/rst_pwr_pkg.sv
package rst_pwr_pkg;
  // apb register byte addresses
  localparam logic [7:0] PMC_ADDR = 8'h00;   // power_mgmt_control
  localparam logic [7:0] HWC_ADDR = 8'h04;   // hardware_config
  localparam logic [7:0] EEC_ADDR = 8'h08;   // eeprom_command
  localparam logic [7:0] WAKE_ADDR = 8'h0C;  // wake test register
  localparam logic [7:0] PHYC_ADDR = 8'h10;  // phy basic control
  localparam logic [7:0] PHYS_ADDR = 8'h14;  // phy basic status
  localparam logic [7:0] PHYM_ADDR = 8'h18;  // phy mode control/status
  localparam logic [7:0] PHYI_ADDR = 8'h1C;  // phy interrupt source
  localparam logic [7:0] PHYE_ADDR = 8'h20;  // phy interrupt enable
  localparam logic [7:0] NOT_AFFECTED_BY_SOFT_RESET_ADDR = 8'h24;  // scratch kept over soft reset
  // field positions
  localparam int PMC_READY_BIT = 0;
  localparam int PMC_MODE_LSB = 12;
  localparam int PMC_PHY_RST_BIT = 10;
  localparam int HWC_SOFT_RESET_BIT_BIT = 0;
  localparam int EEC_BUSY_BIT = 31;
  localparam int PHYC_RST_BIT = 15;
  localparam int PHYC_PDN_BIT = 11;
  localparam int PHYS_LINK_BIT = 2;
  localparam int PHYM_EDPD_BIT = 13;
  localparam int PHYM_EON_BIT = 1;
  localparam int PHYI_EON_BIT = 1;
  // reset values
  localparam logic [31:0] NOT_AFFECTED_BY_SOFT_RESET_RST = 32'h0000_0000;
  localparam logic [31:0] BAD_ADDR_DATA = 32'h0000_0000;
  // timing, in nanoseconds, and clock
  localparam int CLK_NS = 50;
  localparam int POR_NS = 22_000_000;
  localparam int WAKE_NS = 2_000_000;
  localparam int SOFT_RESET_BIT_NS = 2_000;
  localparam int PHY_RST_NS = 100_000;
  localparam int POR_CYC = POR_NS / CLK_NS;
  localparam int WAKE_CYC = WAKE_NS / CLK_NS;
  localparam int SOFT_RESET_BIT_CYC = SOFT_RESET_BIT_NS / CLK_NS;
  localparam int PHY_RST_CYC = PHY_RST_NS / CLK_NS;
  localparam int EE_PROBE_CYC = 64;
  localparam int LINK_CYC = 32;
  // power states
  typedef enum logic [1:0] {
    PM_D0 = 2'b00,
    PM_D1 = 2'b01,
    PM_D2 = 2'b10
  } pm_mode_e;
  // apb request carrier
  typedef struct packed {
    logic sel;
    logic en;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } apb_req_s;
endpackage

// >>> test/host_cpu_model.sv
`timescale 1ns/1ps
module host_cpu_model (
  // clock
  input wire logic clk_i,
  // apb master side
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o,
  input wire logic pready_i,
  input wire logic pslverr_i,
  input wire logic [31:0] prdata_i
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0000_0000;
  end

  // request held until pready is seen high; no cycle count is assumed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= wd;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_i !== 1'b1);
    rd = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask

  // read-only polling; gives up long before a host would declare an error
  task automatic poll(input logic [7:0] a, input int b, input logic v, input int lim,
                      output logic ok);
    logic [31:0] d;
    logic e;
    ok = 1'b0;
    for (int i = 0; i < lim && !ok; i++) begin
      xfer(1'b0, a, 32'h0000_0000, d, e);
      ok = (d[b] === v);
    end
  endtask
endmodule // host_cpu_model

// >>> test/reset_and_phy_powerdown_ctrl_test.sv
`timescale 1ns/1ps
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin num_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (x)); end end
module reset_and_phy_powerdown_ctrl_test;
  localparam logic [7:0] PMC = rst_pwr_pkg::PMC_ADDR;
  localparam logic [7:0] HWC = rst_pwr_pkg::HWC_ADDR;
  localparam logic [7:0] EEC = rst_pwr_pkg::EEC_ADDR;
  localparam logic [7:0] WAKE = rst_pwr_pkg::WAKE_ADDR;
  localparam logic [7:0] PHYC = rst_pwr_pkg::PHYC_ADDR;
  localparam logic [7:0] PHYS = rst_pwr_pkg::PHYS_ADDR;
  localparam logic [7:0] PHYM = rst_pwr_pkg::PHYM_ADDR;
  localparam logic [7:0] PHYI = rst_pwr_pkg::PHYI_ADDR;
  localparam logic [7:0] PHYE = rst_pwr_pkg::PHYE_ADDR;
  localparam logic [7:0] KEEP = rst_pwr_pkg::NOT_AFFECTED_BY_SOFT_RESET_ADDR;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pin_n = 1'b1;
  logic energy = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, powered, tx_allow, irq, dev_rst, e, ok;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  int num_errors = 0;
  int cmp_count = 0;

  always #25 clk = ~clk;

  reset_and_phy_powerdown_ctrl #(.POR_CYCLES(50), .WAKE_CYCLES(20), .PHY_RST_CYCLES(10))
    i_reset_and_phy_powerdown_ctrl (.CORE_CLK_I(clk), .SYS_RST_I(rst),
    .HW_RESET_PIN_N_I(pin_n), .LINE_ENERGY_I(energy), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .PRDATA_O(prdata), .PHY_POWERED_O(powered),
    .PHY_TX_ALLOW_O(tx_allow), .PHY_IRQ_O(irq), .DEV_RESET_O(dev_rst));

  host_cpu_model i_host_cpu_model (.clk_i(clk), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .pready_i(pready),
    .pslverr_i(pslverr), .prdata_i(prdata));

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    i_host_cpu_model.xfer(1'b1, a, v, d, e);
  endtask
  task automatic rd(input logic [7:0] a);
    i_host_cpu_model.xfer(1'b0, a, 32'h0000_0000, d, e);
  endtask
  task automatic pl(input logic [7:0] a, input int b, input logic v, input int lim);
    i_host_cpu_model.poll(a, b, v, lim, ok);
  endtask

  task automatic t_por();
    rd(PMC);
    `CHK(d[0], 1'b0)
    `CHK(dev_rst, 1'b1)
    pl(PMC, 0, 1'b1, 40);
    `CHK(ok, 1'b1)
    `CHK(dev_rst, 1'b0)
    rd(8'h40);
    `CHK(e, 1'b1)
    `CHK(d, rst_pwr_pkg::BAD_ADDR_DATA)
  endtask

  task automatic t_soft_reset_bit();
    wr(KEEP, 32'hA5C3_5A3C);
    wr(HWC, 32'h0000_0001);
    rd(HWC);
    `CHK(d[0], 1'b1)
    pl(HWC, 0, 1'b0, 30);
    `CHK(ok, 1'b1)
    rd(EEC);
    `CHK(d[31], 1'b1)
    pl(EEC, 31, 1'b0, 40);
    `CHK(ok, 1'b1)
    rd(KEEP);
    `CHK(d, 32'hA5C3_5A3C)
  endtask

  task automatic t_pin();
    pin_n <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK(dev_rst, 1'b1)
    pin_n <= 1'b1;
    rd(EEC);
    `CHK(d[31], 1'b1)
    pl(PMC, 0, 1'b1, 60);
    `CHK(ok, 1'b1)
  endtask

  task automatic t_phy();
    wr(PMC, 32'h0000_0400);
    rd(PMC);
    `CHK(d[10], 1'b1)
    `CHK(tx_allow, 1'b0)
    pl(PMC, 10, 1'b0, 20);
    `CHK(ok, 1'b1)
    pl(PHYS, 2, 1'b1, 30);
    `CHK(ok, 1'b1)
    wr(PHYC, 32'h0000_8000);
    rd(PHYC);
    `CHK(d[15], 1'b1)
    pl(PHYC, 15, 1'b0, 20);
    `CHK(ok, 1'b1)
  endtask

  task automatic t_pdn();
    wr(PHYC, 32'h0000_0800);
    rd(PHYC);
    `CHK(d[11], 1'b1)
    `CHK(powered, 1'b0)
    wr(PHYC, 32'h0000_0000);
    rd(PHYS);
    `CHK(d[2], 1'b0)
    `CHK(powered, 1'b1)
    pl(PHYS, 2, 1'b1, 30);
    `CHK(ok, 1'b1)
  endtask

  task automatic t_edpd();
    energy <= 1'b0;
    wr(PHYE, 32'h0000_0002);
    wr(PHYM, 32'h0000_2000);
    rd(PHYM);
    `CHK(d[1], 1'b0)
    `CHK(powered, 1'b0)
    `CHK(tx_allow, 1'b0)
    energy <= 1'b1;
    pl(PHYM, 1, 1'b1, 10);
    `CHK(ok, 1'b1)
    repeat (4) @(posedge clk);
    `CHK(powered, 1'b1)
    `CHK(tx_allow, 1'b1)
    `CHK(irq, 1'b1)
    rd(PHYI);
    `CHK(d[1], 1'b1)
    rd(PHYM);
    `CHK(d[13], 1'b1)
    `CHK(irq, 1'b0)
    wr(PHYM, 32'h0000_0000);
    energy <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(powered, 1'b1)
    energy <= 1'b1;
  endtask

  task automatic t_sleep();
    for (int m = 1; m < 3; m++) begin
      wr(PMC, {18'h0, m[1:0], 12'h000});
      rd(PMC);
      `CHK(d[0], 1'b0)
      wr(WAKE, 32'h0000_0000);
      pl(PMC, 0, 1'b1, 20);
      `CHK(ok, 1'b1)
      rd(PMC);
      `CHK(d[13:12], rst_pwr_pkg::PM_D0)
    end
  endtask

  task automatic complete_run();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // whole sequence needs under 2000 cycles
  initial begin
    repeat (6000) @(posedge clk);
    num_errors++;
    complete_run();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_por();
    t_soft_reset_bit();
    t_pin();
    t_phy();
    t_pdn();
    t_edpd();
    t_sleep();
    complete_run();
  end
endmodule // reset_and_phy_powerdown_ctrl_test
